// file: fsd_unit.sv
`timescale 1ns/1ps
`default_nettype none

package fsd_pkg;

  localparam int FSD_EXT_W = 80;
  localparam int FSD_EXP_W = 15;
  localparam int FSD_FRAC_W = 63;
  localparam int FSD_REGS = 8;
  localparam int FSD_IDX_W = 3;
  localparam int FSD_SIGN_POS = 79;
  localparam int FSD_EXP_LSB = 64;
  localparam int FSD_INT_POS = 63;
  localparam logic [14:0] FSD_EXP_MAX = 15'h7fff;
  localparam logic [14:0] FSD_EXP_ZERO = 15'h0000;
  localparam logic [14:0] FSD_EXP_ONE = 15'h0001;
  localparam logic [7:0] FSD_ESC_LO = 8'hd8;
  localparam logic [7:0] FSD_ESC_HI = 8'hdf;
  localparam logic [14:0] FSD_SGL_ADJ = 15'h3f80;
  localparam logic [14:0] FSD_DBL_ADJ = 15'h3c00;
  localparam logic [7:0] FSD_SGL_EMAX = 8'hff;
  localparam logic [10:0] FSD_DBL_EMAX = 11'h7ff;
  localparam logic [2:0] FSD_TOP_RST = 3'h0;
  localparam logic [7:0] FSD_TAG_RST = 8'h00;
  localparam logic FSD_CMOV_PRESENT = 1'b1;

  typedef enum logic [3:0] {
    FSD_OP_FLOAD_MEM = 4'h0,
    FSD_OP_FLOAD_REG = 4'h1,
    FSD_OP_ILOAD = 4'h2,
    FSD_OP_DLOAD = 4'h3,
    FSD_OP_FSTORE = 4'h4,
    FSD_OP_ISTORE = 4'h5,
    FSD_OP_FSTORE_POP = 4'h6,
    FSD_OP_ISTORE_POP = 4'h7,
    FSD_OP_DSTORE_POP = 4'h8,
    FSD_OP_FSTORE_POP_REG = 4'h9,
    FSD_OP_SWAP = 4'ha,
    FSD_OP_CMOV = 4'hb,
    FSD_OP_NONE = 4'hf
  } fsd_op_e;

  typedef enum logic [2:0] {
    FSD_CC_BELOW = 3'h0,
    FSD_CC_NOT_BELOW = 3'h1,
    FSD_CC_EQUAL = 3'h2,
    FSD_CC_NOT_EQUAL = 3'h3,
    FSD_CC_BELOW_OR_EQUAL = 3'h4,
    FSD_CC_ABOVE = 3'h5,
    FSD_CC_UNORDERED = 3'h6,
    FSD_CC_ORDERED = 3'h7
  } fsd_cc_e;

  typedef enum logic [1:0] {
    FSD_FMT_SINGLE = 2'h0,
    FSD_FMT_DOUBLE = 2'h1,
    FSD_FMT_EXTENDED = 2'h2,
    FSD_FMT_OTHER = 2'h3
  } fsd_fmt_e;

  typedef enum logic [1:0] {
    FSD_KIND_FLOAT = 2'h0,
    FSD_KIND_INT = 2'h1,
    FSD_KIND_DECIMAL = 2'h2,
    FSD_KIND_NONE = 2'h3
  } fsd_kind_e;

endpackage : fsd_pkg

module fsd_unit
  import fsd_pkg::*;
#(
  parameter int REGS = FSD_REGS,
  parameter int IDX_W = FSD_IDX_W,
  parameter int EXT_W = FSD_EXT_W
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic issue_valid_i,
  input wire logic [7:0] opcode_byte_i,
  input wire logic [3:0] op_i,
  input wire logic [IDX_W-1:0] sel_idx_i,
  input wire logic has_immediate_i,
  input wire logic [2:0] cond_i,
  input wire logic carry_flag_i,
  input wire logic zero_flag_i,
  input wire logic parity_flag_i,
  input wire logic [1:0] mem_fmt_i,
  input wire logic [EXT_W-1:0] mem_rd_data_i,
  output logic route_fpu_o,
  output logic cmov_feature_o,
  output logic done_o,
  output logic refused_o,
  output logic invalid_o,
  output logic denormal_o,
  output logic cond_taken_o,
  output logic mem_wr_valid_o,
  output logic [EXT_W-1:0] mem_wr_data_o,
  output logic [1:0] mem_wr_kind_o,
  output logic [1:0] mem_wr_fmt_o,
  output logic [IDX_W-1:0] top_o,
  output logic [REGS-1:0] tag_valid_o,
  output logic [EXT_W-1:0] head_value_o
);

  // Stack storage and pointer
  logic [EXT_W-1:0] stk [REGS];
  logic [IDX_W-1:0] top;
  logic [REGS-1:0] tag;

  // Widen a memory float into extended form, normalising denormals
  function automatic logic [79:0] fsd_widen(input logic sgn, input logic [14:0] ebase,
                                            input logic [63:0] m, input logic emax);
    logic [6:0] lz;
    logic found;
    logic [63:0] mn;
    lz = 7'h00;
    found = 1'b0;
    mn = m;
    for (int i = 63; i >= 0; i--) begin
      if (!found && !m[i]) begin
        lz = lz + 7'h01;
      end else begin
        found = 1'b1;
      end
    end
    if (emax) begin
      fsd_widen = {sgn, FSD_EXP_MAX, 1'b1, m[62:0]};
    end else if (m == 64'h0) begin
      fsd_widen = {sgn, 79'h0};
    end else begin
      mn = m << lz;
      fsd_widen = {sgn, ebase - {8'h00, lz}, mn};
    end
  endfunction : fsd_widen

  // Pseudo-denormals hold the same value as exponent one
  function automatic logic [79:0] fsd_canon(input logic [79:0] v);
    if (v[78:64] == FSD_EXP_ZERO && v[FSD_INT_POS]) begin
      fsd_canon = {v[FSD_SIGN_POS], FSD_EXP_ONE, v[63:0]};
    end else begin
      fsd_canon = v;
    end
  endfunction : fsd_canon

  // Decode and issue qualification
  wire esc_class = (opcode_byte_i >= FSD_ESC_LO) && (opcode_byte_i <= FSD_ESC_HI);
  assign route_fpu_o = esc_class;
  wire exec = issue_valid_i & esc_class & ~has_immediate_i;
  wire refuse = issue_valid_i & (~esc_class | has_immediate_i);
  fsd_op_e op;
  assign op = fsd_op_e'(op_i);
  fsd_cc_e cc;
  assign cc = fsd_cc_e'(cond_i);

  // Register addressing relative to head
  wire [IDX_W-1:0] sel_phys = top + sel_idx_i;
  wire [IDX_W-1:0] push_phys = top - {{(IDX_W-1){1'b0}}, 1'b1};
  wire [IDX_W-1:0] pop_top = top + {{(IDX_W-1){1'b0}}, 1'b1};
  wire [EXT_W-1:0] head_val = stk[top];
  wire [EXT_W-1:0] sel_val = stk[sel_phys];

  // Memory float widening
  wire [EXT_W-1:0] wide_sgl = fsd_widen(mem_rd_data_i[31],
    (mem_rd_data_i[30:23] == 8'h00) ? (FSD_SGL_ADJ + FSD_EXP_ONE) : (FSD_SGL_ADJ + {7'h00, mem_rd_data_i[30:23]}),
    {(mem_rd_data_i[30:23] != 8'h00), mem_rd_data_i[22:0], 40'h0},
    mem_rd_data_i[30:23] == FSD_SGL_EMAX);
  wire [EXT_W-1:0] wide_dbl = fsd_widen(mem_rd_data_i[63],
    (mem_rd_data_i[62:52] == 11'h000) ? (FSD_DBL_ADJ + FSD_EXP_ONE) : (FSD_DBL_ADJ + {4'h0, mem_rd_data_i[62:52]}),
    {(mem_rd_data_i[62:52] != 11'h000), mem_rd_data_i[51:0], 11'h000},
    mem_rd_data_i[62:52] == FSD_DBL_EMAX);
  wire [EXT_W-1:0] mem_ext = (mem_fmt_i == FSD_FMT_SINGLE) ? wide_sgl :
                             (mem_fmt_i == FSD_FMT_DOUBLE) ? wide_dbl : mem_rd_data_i;

  // Operation groups
  wire is_push = (op == FSD_OP_FLOAD_MEM) || (op == FSD_OP_FLOAD_REG) ||
                 (op == FSD_OP_ILOAD) || (op == FSD_OP_DLOAD);
  wire is_mem_store = (op == FSD_OP_FSTORE) || (op == FSD_OP_ISTORE) || (op == FSD_OP_FSTORE_POP) ||
                      (op == FSD_OP_ISTORE_POP) || (op == FSD_OP_DSTORE_POP);
  wire is_pop = (op == FSD_OP_FSTORE_POP) || (op == FSD_OP_ISTORE_POP) ||
                (op == FSD_OP_DSTORE_POP) || (op == FSD_OP_FSTORE_POP_REG);
  wire is_swap = (op == FSD_OP_SWAP);
  wire is_cmov = (op == FSD_OP_CMOV);
  wire is_legal = is_push || is_mem_store || is_pop || is_swap || is_cmov;

  // Value to push; integer and decimal arrive already converted
  logic [EXT_W-1:0] push_val;
  always_comb begin
    unique case (op)
      FSD_OP_FLOAD_MEM: push_val = mem_ext;
      FSD_OP_FLOAD_REG: push_val = sel_val;
      FSD_OP_ILOAD: push_val = mem_rd_data_i;
      FSD_OP_DLOAD: push_val = mem_rd_data_i;
      default: push_val = head_val;
    endcase
  end

  // Screened operand: the value the operation reads
  wire [EXT_W-1:0] src_val = is_push ? push_val : ((is_swap || is_cmov) ? sel_val : head_val);
  logic cls_invalid;
  logic cls_denorm;
  fsd_classify #(
    .EXP_W(FSD_EXP_W),
    .FRAC_W(FSD_FRAC_W)
  ) u_screen (
    .value_i(src_val),
    .pseudo_nan_o(),
    .pseudo_inf_o(),
    .unnormal_o(),
    .pseudo_denorm_o(),
    .invalid_o(cls_invalid),
    .denormal_o(cls_denorm)
  );

  // Condition test on the integer status word
  logic cond_met;
  always_comb begin
    unique case (cc)
      FSD_CC_BELOW: cond_met = carry_flag_i;
      FSD_CC_NOT_BELOW: cond_met = ~carry_flag_i;
      FSD_CC_EQUAL: cond_met = zero_flag_i;
      FSD_CC_NOT_EQUAL: cond_met = ~zero_flag_i;
      FSD_CC_BELOW_OR_EQUAL: cond_met = carry_flag_i | zero_flag_i;
      // Taken as the true negation of below-or-equal
      FSD_CC_ABOVE: cond_met = ~carry_flag_i & ~zero_flag_i;
      FSD_CC_UNORDERED: cond_met = parity_flag_i;
      FSD_CC_ORDERED: cond_met = ~parity_flag_i;
    endcase
  end

  // An invalid operand aborts all state change
  wire go = exec & is_legal & ~cls_invalid;
  wire do_push = go & is_push;
  wire do_store = go & is_mem_store;
  wire do_pop = go & is_pop;
  wire do_cmov = go & is_cmov & cond_met;
  wire do_swap = go & is_swap;
  wire do_copy = go & (op == FSD_OP_FSTORE_POP_REG);

  // Up to two register writes per operation
  wire wr_a_en = do_push | do_swap | do_cmov | do_copy;
  wire [IDX_W-1:0] wr_a_idx = do_push ? push_phys : ((do_swap || do_copy) ? sel_phys : top);
  wire [EXT_W-1:0] wr_a_val = fsd_canon(do_push ? push_val : ((do_swap || do_copy) ? head_val : sel_val));
  wire wr_b_en = do_swap & (sel_phys != top);
  wire [EXT_W-1:0] wr_b_val = fsd_canon(sel_val);

  // Tag and pointer next state
  logic [REGS-1:0] next_tag;
  logic [IDX_W-1:0] next_top;
  always_comb begin
    next_tag = tag;
    next_top = top;
    if (do_push) begin
      next_tag[push_phys] = 1'b1;
      next_top = push_phys;
    end
    if (do_copy) begin
      next_tag[sel_phys] = tag[top];
    end
    if (do_swap) begin
      next_tag[sel_phys] = tag[top];
      next_tag[top] = tag[sel_phys];
    end
    if (do_cmov) begin
      next_tag[top] = tag[sel_phys];
    end
    // Clear last so a pop onto itself leaves the head empty
    if (do_pop) begin
      next_tag[top] = 1'b0;
      next_top = pop_top;
    end
  end

  // Store kind and format for the memory side
  wire [1:0] st_kind = ((op == FSD_OP_ISTORE) || (op == FSD_OP_ISTORE_POP)) ? FSD_KIND_INT :
                       (op == FSD_OP_DSTORE_POP) ? FSD_KIND_DECIMAL : FSD_KIND_FLOAT;

  // Register array; no reset so it maps onto plain storage
  always_ff @(posedge mclk_i) begin
    if (wr_a_en) begin
      stk[wr_a_idx] <= wr_a_val;
    end
    if (wr_b_en) begin
      stk[top] <= wr_b_val;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      top <= FSD_TOP_RST;
      tag <= FSD_TAG_RST;
    end else begin
      top <= next_top;
      tag <= next_tag;
    end
  end

  // Registered status pulses
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      refused_o <= 1'b0;
      invalid_o <= 1'b0;
      denormal_o <= 1'b0;
      cond_taken_o <= 1'b0;
    end else begin
      done_o <= exec & is_legal;
      refused_o <= refuse | (exec & ~is_legal);
      invalid_o <= exec & is_legal & cls_invalid;
      denormal_o <= go & cls_denorm;
      cond_taken_o <= do_cmov;
    end
  end

  // Memory write port; conversion to the target format is outside
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_wr_valid_o <= 1'b0;
      mem_wr_data_o <= '0;
      mem_wr_kind_o <= FSD_KIND_NONE;
      mem_wr_fmt_o <= FSD_FMT_EXTENDED;
    end else if (do_store) begin
      mem_wr_valid_o <= 1'b1;
      mem_wr_data_o <= fsd_canon(head_val);
      mem_wr_kind_o <= st_kind;
      mem_wr_fmt_o <= mem_fmt_i;
    end else begin
      mem_wr_valid_o <= 1'b0;
    end
  end

  // Observed head value follows the committed state
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_value_o <= '0;
    end else if (wr_a_en && wr_a_idx == next_top) begin
      head_value_o <= wr_a_val;
    end else if (wr_b_en) begin
      head_value_o <= wr_b_val;
    end else begin
      head_value_o <= stk[next_top];
    end
  end

  assign top_o = top;
  assign tag_valid_o = tag;
  assign cmov_feature_o = FSD_CMOV_PRESENT;

endmodule : fsd_unit

`default_nettype wire

// file: fsd_classify.sv
`timescale 1ns/1ps
`default_nettype none

// Standalone so it compiles before the package
module fsd_classify
#(
  parameter int EXP_W = 15,
  parameter int FRAC_W = 63
) (
  input wire logic [EXP_W+FRAC_W+1:0] value_i,
  output logic pseudo_nan_o,
  output logic pseudo_inf_o,
  output logic unnormal_o,
  output logic pseudo_denorm_o,
  output logic invalid_o,
  output logic denormal_o
);

  wire [EXP_W-1:0] exp_f = value_i[EXP_W+FRAC_W:FRAC_W+1];
  wire int_bit = value_i[FRAC_W];
  wire frac_nz = |value_i[FRAC_W-1:0];
  wire exp_max = &exp_f;
  wire exp_zero = ~|exp_f;

  assign pseudo_nan_o = exp_max & ~int_bit & frac_nz;
  assign pseudo_inf_o = exp_max & ~int_bit & ~frac_nz;
  assign unnormal_o = ~exp_max & ~exp_zero & ~int_bit;
  assign pseudo_denorm_o = exp_zero & int_bit;
  // Unsupported encodings are flagged invalid rather than computed with
  assign invalid_o = pseudo_nan_o | pseudo_inf_o | unnormal_o;
  // True denormals raise the same flag as pseudo-denormals
  assign denormal_o = pseudo_denorm_o | (exp_zero & frac_nz);

endmodule : fsd_classify

`default_nettype wire

// file: fsd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module fsd_mem_model (
  input wire logic rd_en_i,
  input wire logic [2:0] idx_i,
  output logic [79:0] rd_data_o
);
  logic [79:0] tbl;
  always_comb begin
    case (idx_i)
      3'h0: tbl = {48'h0, 32'h3f800000};
      3'h1: tbl = {16'h0, 64'h4000000000000000};
      3'h2: tbl = 80'h4000c000000000000000;
      3'h3: tbl = 80'h7fff0000000000000000;
      3'h4: tbl = 80'h00010000000000000000;
      3'h5: tbl = 80'h7fff4000000000000000;
      3'h6: tbl = 80'h00008000000000000001;
      3'h7: tbl = 80'h00004000000000000000;
      default: tbl = 80'h0;
    endcase
  end
  // Released bus shows the inverse, so stale data is never mistaken for valid
  assign rd_data_o = rd_en_i ? tbl : ~tbl;
endmodule : fsd_mem_model

`default_nettype wire

// file: fsd_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none

module fsd_unit_checker
  import fsd_pkg::*;
#(
  parameter int REGS = FSD_REGS,
  parameter int IDX_W = FSD_IDX_W,
  parameter int EXT_W = FSD_EXT_W
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic issue_valid_i,
  input wire logic [7:0] opcode_byte_i,
  input wire logic [3:0] op_i,
  input wire logic has_immediate_i,
  input wire logic [2:0] cond_i,
  input wire logic carry_flag_i,
  input wire logic route_fpu_o,
  input wire logic cmov_feature_o,
  input wire logic done_o,
  input wire logic refused_o,
  input wire logic invalid_o,
  input wire logic denormal_o,
  input wire logic cond_taken_o,
  input wire logic mem_wr_valid_o,
  input wire logic [EXT_W-1:0] mem_wr_data_o,
  input wire logic [IDX_W-1:0] top_o,
  input wire logic [REGS-1:0] tag_valid_o,
  input wire logic [EXT_W-1:0] head_value_o
);
  wire in_rng = opcode_byte_i inside {[FSD_ESC_LO:FSD_ESC_HI]};
  wire ok = issue_valid_i && in_rng && !has_immediate_i;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_ROUTE: assert property (route_fpu_o == in_rng)
    else $error("route flag wrong");
  AST_REFUSE: assert property (issue_valid_i && !ok |=> refused_o && !done_o)
    else $error("bad request not refused");
  AST_FEATURE: assert property (cmov_feature_o)
    else $error("feature bit low");
  AST_INVALID_HOLD: assert property (invalid_o |-> $stable(top_o) && $stable(tag_valid_o) && !mem_wr_valid_o)
    else $error("invalid operand changed state");
  AST_PUSH: assert property (ok && op_i inside {4'h0, 4'h1, 4'h2, 4'h3} |=>
    invalid_o || (top_o == IDX_W'($past(top_o) - 1'b1) && tag_valid_o[top_o]))
    else $error("push pointer wrong");
  AST_POP: assert property (ok && op_i inside {4'h6, 4'h7, 4'h8, 4'h9} |=>
    invalid_o || (top_o == IDX_W'($past(top_o) + 1'b1) && !tag_valid_o[$past(top_o)]))
    else $error("pop pointer or tag wrong");
  AST_STORE: assert property (ok && op_i inside {4'h4, 4'h5} |=>
    invalid_o || (mem_wr_valid_o && $stable(top_o) && mem_wr_data_o == $past(head_value_o)))
    else $error("store wrong");
  AST_CMOV: assert property (ok && op_i == 4'hb && cond_i == 3'h0 |=>
    invalid_o || cond_taken_o == $past(carry_flag_i))
    else $error("below move wrong");
  AST_NO_PSEUDO: assert property (mem_wr_valid_o |-> !(mem_wr_data_o[78:64] == FSD_EXP_ZERO && mem_wr_data_o[63]))
    else $error("pseudo-denormal written");
  AST_DENORM: assert property (denormal_o |-> done_o && !invalid_o &&
    !(head_value_o[78:64] == FSD_EXP_ZERO && head_value_o[63]))
    else $error("denormal handling wrong");
  COV_PUSH: cover property (ok && op_i == 4'h0 ##1 done_o);
  COV_REFUSE: cover property (refused_o);
  COV_CMOV: cover property (cond_taken_o);
  COV_INVALID: cover property (invalid_o);
endmodule : fsd_unit_checker

bind fsd_unit fsd_unit_checker #(.REGS(REGS), .IDX_W(IDX_W), .EXT_W(EXT_W)) fsd_unit_checker_i (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .issue_valid_i(issue_valid_i),
  .opcode_byte_i(opcode_byte_i),
  .op_i(op_i),
  .has_immediate_i(has_immediate_i),
  .cond_i(cond_i),
  .carry_flag_i(carry_flag_i),
  .route_fpu_o(route_fpu_o),
  .cmov_feature_o(cmov_feature_o),
  .done_o(done_o),
  .refused_o(refused_o),
  .invalid_o(invalid_o),
  .denormal_o(denormal_o),
  .cond_taken_o(cond_taken_o),
  .mem_wr_valid_o(mem_wr_valid_o),
  .mem_wr_data_o(mem_wr_data_o),
  .top_o(top_o),
  .tag_valid_o(tag_valid_o),
  .head_value_o(head_value_o)
);

`default_nettype wire

// file: fsd_unit_test.sv
`timescale 1ns/1ps
`default_nettype none

module fsd_unit_test;
  import fsd_pkg::*;
  localparam logic [79:0] E1 = 80'h3fff8000000000000000;
  localparam logic [79:0] E2 = 80'h40008000000000000000;
  localparam logic [79:0] E3 = 80'h4000c000000000000000;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic issue_valid_i = 1'b0;
  logic has_immediate_i = 1'b0;
  logic carry_flag_i = 1'b0;
  logic zero_flag_i = 1'b0;
  logic parity_flag_i = 1'b0;
  logic [7:0] opcode_byte_i = 8'hd9;
  logic [3:0] op_i = 4'hf;
  logic [2:0] sel_idx_i = 3'h0;
  logic [2:0] cond_i = 3'h0;
  logic [2:0] idx = 3'h0;
  logic [1:0] mem_fmt_i = 2'h2;
  wire [79:0] mem_rd_data_i;
  logic route_fpu_o, cmov_feature_o, done_o, refused_o, invalid_o, denormal_o, cond_taken_o, mem_wr_valid_o;
  logic [79:0] mem_wr_data_o, head_value_o;
  logic [1:0] mem_wr_kind_o, mem_wr_fmt_o;
  logic [2:0] top_o;
  logic [7:0] tag_valid_o;
  logic [79:0] hd;
  logic [2:0] fl;
  logic tk;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire [7:0] flg = {2'h0, cond_taken_o, done_o, refused_o, invalid_o, denormal_o, mem_wr_valid_o};
  wire [7:0] wk = {4'h0, mem_wr_kind_o, mem_wr_fmt_o};

  fsd_unit fsd_unit_i (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .issue_valid_i(issue_valid_i),
    .opcode_byte_i(opcode_byte_i),
    .op_i(op_i),
    .sel_idx_i(sel_idx_i),
    .has_immediate_i(has_immediate_i),
    .cond_i(cond_i),
    .carry_flag_i(carry_flag_i),
    .zero_flag_i(zero_flag_i),
    .parity_flag_i(parity_flag_i),
    .mem_fmt_i(mem_fmt_i),
    .mem_rd_data_i(mem_rd_data_i),
    .route_fpu_o(route_fpu_o),
    .cmov_feature_o(cmov_feature_o),
    .done_o(done_o),
    .refused_o(refused_o),
    .invalid_o(invalid_o),
    .denormal_o(denormal_o),
    .cond_taken_o(cond_taken_o),
    .mem_wr_valid_o(mem_wr_valid_o),
    .mem_wr_data_o(mem_wr_data_o),
    .mem_wr_kind_o(mem_wr_kind_o),
    .mem_wr_fmt_o(mem_wr_fmt_o),
    .top_o(top_o),
    .tag_valid_o(tag_valid_o),
    .head_value_o(head_value_o)
  );
  fsd_mem_model fsd_mem_model_i (.rd_en_i(issue_valid_i), .idx_i(idx), .rd_data_o(mem_rd_data_i));

  always #2.5 mclk_i = ~mclk_i;

  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // Generous ceiling; the sequence needs about a hundred cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk_v(input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_f(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_f

  task automatic st(input logic [2:0] t, input logic [7:0] tg, input logic [79:0] h);
    chk_f({5'h0, top_o}, {5'h0, t});
    chk_f(tag_valid_o, tg);
    chk_v(head_value_o, h);
  endtask : st

  // One request, answer visible at the following falling edge
  task automatic req(input logic [3:0] o, input logic [2:0] s, input logic [2:0] ix, input logic [1:0] f);
    @(negedge mclk_i);
    {issue_valid_i, op_i, sel_idx_i, idx, mem_fmt_i} = {1'b1, o, s, ix, f};
    @(negedge mclk_i);
    issue_valid_i = 1'b0;
  endtask : req

  function automatic logic ccx(input logic [2:0] c, input logic [2:0] f);
    case (c)
      3'h0: return f[2];
      3'h1: return !f[2];
      3'h2: return f[1];
      3'h3: return !f[1];
      3'h4: return f[2] | f[1];
      3'h5: return !(f[2] | f[1]);
      3'h6: return f[0];
      default: return !f[0];
    endcase
  endfunction : ccx

  initial begin
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    st(3'h0, 8'h00, 80'h0);
    chk_f({7'h0, cmov_feature_o}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      opcode_byte_i = 8'(32'hd7d8dfe0 >> (24 - 8 * i));
      #1;
      chk_f({7'h0, route_fpu_o}, {7'h0, i == 1 || i == 2});
    end
    opcode_byte_i = 8'hd9;
    req(4'h0, 3'h0, 3'h0, 2'h0);
    chk_f(flg, 8'h10);
    st(3'h7, 8'h80, E1);
    req(4'h0, 3'h0, 3'h1, 2'h1);
    st(3'h6, 8'hc0, E2);
    req(4'h2, 3'h0, 3'h2, 2'h3);
    st(3'h5, 8'he0, E3);
    req(4'h1, 3'h2, 3'h7, 2'h2);
    st(3'h4, 8'hf0, E1);
    req(4'ha, 3'h1, 3'h7, 2'h2);
    st(3'h4, 8'hf0, E3);
    req(4'h4, 3'h0, 3'h7, 2'h1);
    chk_f(flg, 8'h11);
    chk_v(mem_wr_data_o, E3);
    chk_f(wk, 8'h01);
    st(3'h4, 8'hf0, E3);
    hd = E3;
    for (int c = 0; c < 8; c++) begin
      for (int p = 0; p < 3; p++) begin
        fl = (p == 0) ? 3'h0 : (p == 1) ? 3'h7 : 3'h4;
        {carry_flag_i, zero_flag_i, parity_flag_i} = fl;
        cond_i = c[2:0];
        req(4'hb, 3'h1, 3'h7, 2'h2);
        tk = ccx(c[2:0], fl);
        chk_f(flg, {2'h0, tk, 5'h10});
        if (tk) begin
          hd = E1;
        end
        chk_v(head_value_o, hd);
      end
    end
    req(4'h8, 3'h0, 3'h7, 2'h3);
    chk_f(flg, 8'h11);
    chk_v(mem_wr_data_o, E1);
    chk_f(wk, 8'h0b);
    st(3'h5, 8'he0, E1);
    req(4'h9, 3'h1, 3'h7, 2'h2);
    st(3'h6, 8'hc0, E1);
    req(4'h7, 3'h0, 3'h7, 2'h1);
    chk_f(wk, 8'h05);
    st(3'h7, 8'h80, E1);
    req(4'h6, 3'h0, 3'h7, 2'h0);
    chk_f({5'h0, top_o}, 8'h00);
    chk_f(tag_valid_o, 8'h00);
    for (int k = 3; k < 6; k++) begin
      req(4'h0, 3'h0, k[2:0], 2'h2);
      chk_f(flg, 8'h14);
      chk_f({4'h0, top_o, tag_valid_o[0]}, 8'h00);
    end
    req(4'h0, 3'h0, 3'h6, 2'h2);
    chk_f(flg, 8'h12);
    st(3'h7, 8'h80, 80'h00018000000000000001);
    opcode_byte_i = 8'he0;
    req(4'h0, 3'h0, 3'h0, 2'h0);
    chk_f(flg, 8'h08);
    opcode_byte_i = 8'hd9;
    has_immediate_i = 1'b1;
    req(4'h0, 3'h0, 3'h0, 2'h0);
    chk_f(flg, 8'h08);
    st(3'h7, 8'h80, 80'h00018000000000000001);
    has_immediate_i = 1'b0;
    req(4'h5, 3'h0, 3'h0, 2'h2);
    chk_f(flg, 8'h11);
    chk_v(mem_wr_data_o, 80'h00018000000000000001);
    chk_f(wk, 8'h06);
    st(3'h7, 8'h80, 80'h00018000000000000001);
    req(4'h3, 3'h0, 3'h2, 2'h3);
    chk_f(flg, 8'h10);
    st(3'h6, 8'hc0, E3);
    req(4'h0, 3'h0, 3'h7, 2'h2);
    chk_f(flg, 8'h12);
    st(3'h5, 8'he0, 80'h00004000000000000000);
    rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    st(3'h0, 8'h00, 80'h0);
    chk_f(wk, 8'h0e);
    wrap_up();
  end
endmodule : fsd_unit_test

`default_nettype wire
